// ### verilog/pxirq_ctrl.sv
/*
  pin interrupt unit: pin capture, redirection table, message delivery,
  legacy virtual-wire messages and end-of-interrupt handling.
  assumes a register master on ref_clk and upstream sinks with ready.
*/
// Notes on behaviour
// - sixteen pins, edge or level, either polarity
// - synchronise pins, deliver only when unmasked
// - pins feed table entries 15 to 0
// - hot-plug interrupt fixed to entry 23
// - other entries only via virtual wires
// - memory writes outside the window pass upstream unmodified
// - masked inputs make legacy messages, unmasked not
// - assert message on rising or of inputs
// - deassert message on falling or of inputs
// - pins grouped modulo four onto four lines
// - no posted buffer flush on interrupt
// - end-of-interrupt clears every vector-matching pending
// - end-of-interrupt never goes to parallel bus
// - request flag causes upstream memory write
// - address top FEE, destination fields, low zero
// - hint set only for lowest priority mode
// - address bit two is destination mode
// - data built from entry fields, rest zero
// - status one for edge, level follows input
`timescale 1ns/1ps
module pxirq_ctrl (
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  input  wire logic [8:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  input  wire logic [15:0]            bus_irq_pins,
  input  wire logic                   hotplug_irq_a,
  input  wire logic                   hotplug_irq_b,
  input  wire logic [3:0]             peer_intx,
  input  wire logic                   vw_valid,
  input  wire logic [4:0]             vw_entry,
  input  wire logic                   vw_level,
  input  wire logic                   eoi_valid,
  input  wire logic [7:0]             eoi_vector,
  input  wire logic                   bus_wr_valid,
  input  wire pxirq_pkg::pxirq_mwr_s   bus_wr,
  output logic                        bus_wr_ready,
  output logic                        up_valid,
  output pxirq_pkg::pxirq_mwr_s        up_msg,
  input  wire logic                   up_ready,
  output logic                        intx_valid,
  output pxirq_pkg::pxirq_intx_s       intx_msg,
  input  wire logic                   intx_ready
);
  localparam int NE = pxirq_pkg::NUM_ENT;

  pxirq_pkg::pxirq_entry_s tbl_reg [NE];
  logic [pxirq_pkg::SYNC_W-1:0] sync_w;
  logic [NE-1:0] raw_lvl;
  logic [NE-1:0] lvl;
  logic [NE-1:0] prev_reg;
  logic [NE-1:0] req_reg;
  logic [NE-1:0] kind_reg;
  logic [NE-1:0] pend_reg;
  logic [NE-1:0] vw_lvl_reg;
  logic [NE-1:0] grant;
  logic [NE-1:0] pend_set;
  logic          apic_en_reg;
  logic [11:0]   win_base_reg;
  logic [11:0]   win_lim_reg;
  logic [4:0]    sel_idx;
  logic          sel_valid;
  logic          take_bus;
  logic          fwd_bus;
  logic          load_ent;
  logic [3:0]    line_lvl;
  logic [3:0]    sent_reg;
  logic [1:0]    chg_idx;
  logic          chg_any;
  logic          ent_hit;
  logic [4:0]    ent_idx;
  logic [31:0]   ent_lo;
  logic [31:0]   ent_hi;

  // pins and both hot-plug sides pass the synchroniser bank
  pxirq_sync #(
    .WIDTH (pxirq_pkg::SYNC_W)
  ) u_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .async_in ({hotplug_irq_b, hotplug_irq_a, bus_irq_pins}),
    .sync_out (sync_w)
  );

  // raw levels per entry: pins low, hot-plug at the top
  always_comb begin
    raw_lvl = vw_lvl_reg;
    raw_lvl[pxirq_pkg::NUM_PINS-1:0] = sync_w[pxirq_pkg::NUM_PINS-1:0];
    raw_lvl[pxirq_pkg::HP_ENT] = sync_w[pxirq_pkg::NUM_PINS];
  end

  // virtual wires may only reach the entries with no pin behind them
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      vw_lvl_reg <= '0;
    end else if (vw_valid && vw_entry >= 5'(pxirq_pkg::VW_FIRST)
                 && vw_entry <= 5'(pxirq_pkg::VW_LAST)) begin
      vw_lvl_reg[vw_entry] <= vw_level;
    end
  end

  // per-entry trigger logic, request and pending flags
  genvar g;
  generate
    for (g = 0; g < NE; g++) begin : g_ent
      logic rise;
      logic fall;
      logic set_a;
      logic set_d;
      localparam bit IS_VW = (g >= pxirq_pkg::VW_FIRST) && (g <= pxirq_pkg::VW_LAST);
      // for pin and hot-plug entries polarity is folded in before edges or levels are looked at
      assign lvl[g]  = IS_VW ? vw_lvl_reg[g] : (raw_lvl[g] ^ tbl_reg[g].pol);
      assign rise    = lvl[g] && !prev_reg[g];
      assign fall    = !lvl[g] && prev_reg[g];
      // edge mode sends assertion only; level mode waits for the pending flag
      assign set_a   = !tbl_reg[g].mask && (tbl_reg[g].trig ?
                       (lvl[g] && !pend_reg[g] && !req_reg[g]) : rise);
      assign set_d   = !tbl_reg[g].mask && tbl_reg[g].trig && fall && !req_reg[g];
      assign pend_set[g] = grant[g] && tbl_reg[g].trig && kind_reg[g];

      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          prev_reg[g] <= 1'b0;
        end else begin
          prev_reg[g] <= lvl[g];
        end
      end

      // a new event beats the grant that clears the flag
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          req_reg[g]  <= 1'b0;
          kind_reg[g] <= 1'b0;
        end else if (set_a || set_d) begin
          req_reg[g]  <= 1'b1;
          kind_reg[g] <= set_a;
        end else if (grant[g]) begin
          req_reg[g]  <= 1'b0;
        end
      end

      // end of interrupt clears all matching entries, a new delivery wins
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          pend_reg[g] <= 1'b0;
        end else if (pend_set[g]) begin
          pend_reg[g] <= 1'b1;
        end else if (eoi_valid && eoi_vector == tbl_reg[g].vec) begin
          pend_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // lowest index request wins; fixed priority keeps the arbiter tiny
  always_comb begin
    sel_idx   = 5'h00;
    sel_valid = 1'b0;
    for (int i = NE - 1; i >= 0; i--) begin
      if (req_reg[i]) begin
        sel_idx   = 5'(i);
        sel_valid = 1'b1;
      end
    end
  end

  // inbound writes outside the bridge window go up untouched and first
  assign take_bus = bus_wr_valid && bus_wr_ready;
  assign fwd_bus  = take_bus && ((bus_wr.addr[31:20] < win_base_reg)
                    || (bus_wr.addr[31:20] > win_lim_reg));
  assign load_ent = sel_valid && apic_en_reg && bus_wr_ready && !take_bus;

  always_comb begin
    grant = '0;
    if (load_ent) begin
      grant[sel_idx] = 1'b1;
    end
  end

  pxirq_msg u_msg (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .load_ent  (load_ent),
    .load_raw  (fwd_bus),
    .ent       (tbl_reg[sel_idx]),
    .kind      (kind_reg[sel_idx]),
    .raw       (bus_wr),
    .out_valid (up_valid),
    .out_msg   (up_msg),
    .out_ready (up_ready),
    .idle      (bus_wr_ready)
  );

  // legacy lines: masked inputs only, pins grouped modulo four, hot-plug sides on lines 0 and 1, peer side or'ed
  always_comb begin
    line_lvl = peer_intx;
    for (int i = 0; i < pxirq_pkg::NUM_PINS; i++) begin
      if (tbl_reg[i].mask) begin
        line_lvl[i % 4] = line_lvl[i % 4] | lvl[i];
      end
    end
    if (tbl_reg[pxirq_pkg::HP_ENT].mask) begin
      line_lvl[0] = line_lvl[0] | lvl[pxirq_pkg::HP_ENT];
      line_lvl[1] = line_lvl[1] | (sync_w[pxirq_pkg::NUM_PINS+1]
                    ^ tbl_reg[pxirq_pkg::HP_ENT].pol);
    end
  end

  // first line whose reported state differs from its level
  always_comb begin
    chg_idx = 2'h0;
    chg_any = 1'b0;
    for (int k = 3; k >= 0; k--) begin
      if (line_lvl[k] != sent_reg[k]) begin
        chg_idx = 2'(k);
        chg_any = 1'b1;
      end
    end
  end

  // assert and deassert follow edges of each line; a pulse that ends while
  // an earlier message still waits for ready is never reported, because the reported state is compared, not the edge itself
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      intx_valid <= 1'b0;
      intx_msg   <= '0;
      sent_reg   <= '0;
    end else if (!intx_valid && chg_any) begin
      intx_valid         <= 1'b1;
      intx_msg.line      <= chg_idx;
      intx_msg.assrt     <= line_lvl[chg_idx];
      sent_reg[chg_idx]  <= line_lvl[chg_idx];
    end else if (intx_valid && intx_ready) begin
      intx_valid <= 1'b0;
    end
  end

  // register decode of the table area
  assign ent_idx = reg_addr[7:3];
  assign ent_hit = reg_addr[8] && (ent_idx < 5'(NE)) && (reg_addr[1:0] == 2'b00);

  // control and window registers written by software
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      apic_en_reg  <= pxirq_pkg::APIC_EN_RST;
      win_base_reg <= pxirq_pkg::WIN_BASE_RST;
      win_lim_reg  <= pxirq_pkg::WIN_LIM_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        pxirq_pkg::OFS_CTRL:     apic_en_reg  <= reg_wdata[pxirq_pkg::BIT_APIC];
        pxirq_pkg::OFS_WIN_BASE: win_base_reg <= reg_wdata[31:pxirq_pkg::BIT_WIN];
        pxirq_pkg::OFS_WIN_LIM:  win_lim_reg  <= reg_wdata[31:pxirq_pkg::BIT_WIN];
        default: ;
      endcase
    end
  end

  // table writes; status and pending bits are read-only views
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NE; i++) begin
        tbl_reg[i] <= pxirq_pkg::ENT_RST;
      end
    end else if (reg_wr && ent_hit) begin
      if (reg_addr[2]) begin
        tbl_reg[ent_idx].dest  <= reg_wdata[31:24];
        tbl_reg[ent_idx].edest <= reg_wdata[23:16];
      end else begin
        tbl_reg[ent_idx].vec   <= reg_wdata[7:0];
        tbl_reg[ent_idx].dlv   <= reg_wdata[10:8];
        tbl_reg[ent_idx].dmode <= reg_wdata[pxirq_pkg::BIT_DMODE];
        tbl_reg[ent_idx].pol   <= reg_wdata[pxirq_pkg::BIT_POL];
        tbl_reg[ent_idx].trig  <= reg_wdata[pxirq_pkg::BIT_TRIG];
        tbl_reg[ent_idx].mask  <= reg_wdata[pxirq_pkg::BIT_MASK];
      end
    end
  end

  // read word views of the selected entry
  always_comb begin
    ent_lo = 32'h0000_0000;
    ent_lo[7:0]  = tbl_reg[ent_idx].vec;
    ent_lo[10:8] = tbl_reg[ent_idx].dlv;
    ent_lo[pxirq_pkg::BIT_DMODE] = tbl_reg[ent_idx].dmode;
    ent_lo[pxirq_pkg::BIT_STAT]  = req_reg[ent_idx];
    ent_lo[pxirq_pkg::BIT_POL]   = tbl_reg[ent_idx].pol;
    ent_lo[pxirq_pkg::BIT_PEND]  = pend_reg[ent_idx];
    ent_lo[pxirq_pkg::BIT_TRIG]  = tbl_reg[ent_idx].trig;
    ent_lo[pxirq_pkg::BIT_MASK]  = tbl_reg[ent_idx].mask;
    ent_hi = {tbl_reg[ent_idx].dest, tbl_reg[ent_idx].edest, 16'h0000};
  end

  // read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      if (ent_hit) begin
        reg_rdata <= reg_addr[2] ? ent_hi : ent_lo;
      end else begin
        case (reg_addr)
          pxirq_pkg::OFS_CTRL:     reg_rdata <= {31'h0000_0000, apic_en_reg};
          pxirq_pkg::OFS_STAT:     reg_rdata <= {23'h00_0000, up_valid, sent_reg, line_lvl};
          pxirq_pkg::OFS_WIN_BASE: reg_rdata <= {win_base_reg, 20'h0_0000};
          pxirq_pkg::OFS_WIN_LIM:  reg_rdata <= {win_lim_reg, 20'h0_0000};
          default:                 reg_rdata <= 32'h0000_0000;
        endcase
      end
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // pin activity only feeds the table and legacy lines; nothing here
  // reaches the inbound posted-write path, so no flush is ever issued
  // and end-of-interrupt input has no route to the parallel bus

  sequence s_grant;
    load_ent;
  endsequence

  sequence s_emit;
    up_valid && !bus_wr_ready;
  endsequence

  property p_deliver;
    @(posedge ref_clk) disable iff (sys_rst)
    s_grant |=> s_emit;
  endproperty
  a_deliver: assert property (p_deliver) else $error("granted entry not emitted");

  property p_mask_gate;
    @(posedge ref_clk) disable iff (sys_rst)
    $rose(req_reg[0]) |-> $past(!tbl_reg[0].mask);
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("masked entry requested");

  property p_eoi_clear;
    @(posedge ref_clk) disable iff (sys_rst)
    (eoi_valid && eoi_vector == tbl_reg[7].vec && !pend_set[7]) |=> !pend_reg[7];
  endproperty
  a_eoi_clear: assert property (p_eoi_clear) else $error("pending not cleared");

  property p_vw_only;
    @(posedge ref_clk) disable iff (sys_rst)
    (vw_valid && vw_entry < 5'h10) |=> $stable(vw_lvl_reg);
  endproperty
  a_vw_only: assert property (p_vw_only) else $error("virtual wire hit pin entry");

  property p_intx_send;
    @(posedge ref_clk) disable iff (sys_rst)
    (chg_any && !intx_valid) |=> (intx_valid && intx_msg.assrt == $past(line_lvl[chg_idx]));
  endproperty
  a_intx_send: assert property (p_intx_send) else $error("legacy message missing");

  property p_intx_deassert;
    @(posedge ref_clk) disable iff (sys_rst)
    (intx_valid && !intx_msg.assrt) |-> !sent_reg[intx_msg.line] || $past(intx_valid);
  endproperty
  a_intx_deassert: assert property (p_intx_deassert) else $error("deassert state off");

  property p_unmasked_quiet;
    @(posedge ref_clk) disable iff (sys_rst)
    (peer_intx == 4'h0 && tbl_reg[pxirq_pkg::HP_ENT].mask == 1'b0
     && tbl_reg[0].mask == 1'b0 && tbl_reg[4].mask == 1'b0 && tbl_reg[8].mask == 1'b0
     && tbl_reg[12].mask == 1'b0) |-> !line_lvl[0];
  endproperty
  a_unmasked_quiet: assert property (p_unmasked_quiet) else $error("unmasked input on line");

  property p_pin_map;
    @(posedge ref_clk) disable iff (sys_rst)
    (tbl_reg[6].mask && lvl[6]) |-> line_lvl[2];
  endproperty
  a_pin_map: assert property (p_pin_map) else $error("pin six not on third line");
endmodule

// ### pkg/pxirq_pkg.sv
/*
  constants and carrier types of the pin interrupt and delivery unit.
  assumes a 32-bit register port with byte addresses and one clock.
*/
package pxirq_pkg;
  // table geometry and fixed routing
  localparam int NUM_PINS = 16;
  localparam int NUM_ENT  = 24;
  localparam int HP_ENT   = 23;
  localparam int VW_FIRST = 16;
  localparam int VW_LAST  = 22;
  localparam int SYNC_W   = 18;

  // register byte offsets
  localparam logic [8:0] OFS_CTRL     = 9'h000;
  localparam logic [8:0] OFS_STAT     = 9'h004;
  localparam logic [8:0] OFS_WIN_BASE = 9'h008;
  localparam logic [8:0] OFS_WIN_LIM  = 9'h00C;
  localparam logic [8:0] OFS_TBL      = 9'h100;

  // low word field positions of a table entry, then window and control bits
  localparam int BIT_DMODE = 11;
  localparam int BIT_STAT  = 12;
  localparam int BIT_POL   = 13;
  localparam int BIT_PEND  = 14;
  localparam int BIT_TRIG  = 15;
  localparam int BIT_MASK  = 16;
  localparam int BIT_WIN   = 20;
  localparam int BIT_APIC  = 0;

  // message formatting
  localparam logic [11:0] MSG_ADDR_TOP = 12'hFEE;
  localparam logic [2:0]  DLV_LOWPRI   = 3'h1;

  // values after reset; base above limit leaves the window empty, so every write goes up
  localparam logic [11:0] WIN_BASE_RST = 12'hFFF;
  localparam logic [11:0] WIN_LIM_RST  = 12'h000;
  localparam logic        APIC_EN_RST  = 1'b0;

  typedef struct packed {
    logic [7:0] dest;
    logic [7:0] edest;
    logic       mask;
    logic       trig;
    logic       pol;
    logic       dmode;
    logic [2:0] dlv;
    logic [7:0] vec;
  } pxirq_entry_s;

  localparam pxirq_entry_s ENT_RST = '{dest: 8'h00, edest: 8'h00, mask: 1'b1,
    trig: 1'b0, pol: 1'b0, dmode: 1'b0, dlv: 3'h0, vec: 8'h00};

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } pxirq_mwr_s;

  typedef struct packed {
    logic       assrt;
    logic [1:0] line;
  } pxirq_intx_s;
endpackage

// ### verilog/pxirq_sync.sv
/*
  two-flop synchroniser bank for the interrupt pins.
  assumes the inputs may change at any time relative to ref_clk.
*/
`timescale 1ns/1ps
module pxirq_sync #(
  parameter int WIDTH = 18
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_reg;
      // first stage feeds only the second stage
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          meta_reg    <= 1'b0;
          sync_out[g] <= 1'b0;
        end else begin
          meta_reg    <= async_in[g];
          sync_out[g] <= meta_reg;
        end
      end
    end
  endgenerate
endmodule

// ### verilog/pxirq_msg.sv
/*
  upstream memory-write output stage and message formatter.
  assumes the caller loads only while idle is high.
*/
`timescale 1ns/1ps
module pxirq_msg (
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   load_ent,
  input  wire logic                   load_raw,
  input  wire pxirq_pkg::pxirq_entry_s ent,
  input  wire logic                   kind,
  input  wire pxirq_pkg::pxirq_mwr_s   raw,
  output logic                        out_valid,
  output pxirq_pkg::pxirq_mwr_s        out_msg,
  input  wire logic                   out_ready,
  output logic                        idle
);
  logic                 raw_reg;
  logic                 hint;
  pxirq_pkg::pxirq_mwr_s fmt;

  // address and data of an interrupt message from its entry
  always_comb begin
    hint      = (ent.dlv == pxirq_pkg::DLV_LOWPRI);
    fmt.addr  = {pxirq_pkg::MSG_ADDR_TOP, ent.dest, ent.edest, hint, ent.dmode, 2'b00};
    fmt.data  = {16'h0000, ent.trig, (ent.trig ? kind : 1'b1), 2'b00,
                 ent.dmode, ent.dlv, ent.vec};
  end

  // one message held until the upstream side takes it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      idle      <= 1'b1;
      raw_reg   <= 1'b0;
      out_msg   <= '0;
    end else if (idle && (load_ent || load_raw)) begin
      out_valid <= 1'b1;
      idle      <= 1'b0;
      raw_reg   <= load_raw;
      out_msg   <= load_raw ? raw : fmt;
    end else if (out_valid && out_ready) begin
      out_valid <= 1'b0;
      idle      <= 1'b1;
    end
  end

  property p_addr_fmt;
    @(posedge ref_clk) disable iff (sys_rst)
    (out_valid && !raw_reg) |-> (out_msg.addr[31:20] == 12'hFEE && out_msg.addr[1:0] == 2'b00);
  endproperty
  a_addr_fmt: assert property (p_addr_fmt) else $error("bad message address top");

  property p_hint;
    @(posedge ref_clk) disable iff (sys_rst)
    (out_valid && !raw_reg) |-> (out_msg.addr[3] == (out_msg.data[10:8] == 3'h1));
  endproperty
  a_hint: assert property (p_hint) else $error("redirection hint wrong");

  property p_dmode;
    @(posedge ref_clk) disable iff (sys_rst)
    (out_valid && !raw_reg) |-> (out_msg.addr[2] == out_msg.data[11]);
  endproperty
  a_dmode: assert property (p_dmode) else $error("destination mode mismatch");

  property p_data_zero;
    @(posedge ref_clk) disable iff (sys_rst)
    (out_valid && !raw_reg) |-> (out_msg.data[31:16] == 16'h0000 && out_msg.data[13:12] == 2'b00);
  endproperty
  a_data_zero: assert property (p_data_zero) else $error("reserved data bits set");

  property p_edge_assert;
    @(posedge ref_clk) disable iff (sys_rst)
    (out_valid && !raw_reg && !out_msg.data[15]) |-> out_msg.data[14];
  endproperty
  a_edge_assert: assert property (p_edge_assert) else $error("edge message not assert");
endmodule

// ### tb/pxirq_sink.sv
/*
  upstream sink model: ready for memory-write and legacy line messages.
  assumes the unit under test holds each valid until it sees ready.
*/
`timescale 1ns/1ps
module pxirq_sink (
  input  wire logic ref_clk,
  input  wire logic slow,
  output logic      up_ready,
  output logic      intx_ready
);
  logic [1:0] cnt_reg = 2'h0;
  // slow mode stalls three cycles in four, so held messages must stand
  always_ff @(posedge ref_clk) begin
    cnt_reg    <= cnt_reg + 2'h1;
    up_ready   <= !slow || cnt_reg == 2'h3;
    intx_ready <= !slow || cnt_reg == 2'h1;
  end
endmodule

// ### tb/pxirq_ctrl_tb.sv
/*
  self-checking bench of the pin interrupt unit with an upstream sink.
  assumes the register map and message timing of the unit under test.
*/
`timescale 1ns/1ps
module pxirq_ctrl_tb;
  logic                  ref_clk       = 1'b0;
  logic                  sys_rst       = 1'b1;
  logic [8:0]            reg_addr      = 9'h000;
  logic [31:0]           reg_wdata     = 32'h0;
  logic                  reg_wr        = 1'b0;
  logic                  reg_rd        = 1'b0;
  logic [31:0]           reg_rdata;
  logic [15:0]           bus_irq_pins  = 16'h0;
  logic                  hotplug_irq_b = 1'b0;
  logic                  hotplug_irq_a = 1'b0;
  logic [3:0]            peer_intx     = 4'h0;
  logic                  vw_valid      = 1'b0;
  logic [4:0]            vw_entry      = 5'h00;
  logic                  vw_level      = 1'b0;
  logic                  eoi_valid     = 1'b0;
  logic [7:0]            eoi_vector    = 8'h00;
  logic                  bus_wr_valid  = 1'b0;
  pxirq_pkg::pxirq_mwr_s bus_wr        = '0;
  logic                  bus_wr_ready;
  logic                  up_valid;
  pxirq_pkg::pxirq_mwr_s up_msg;
  logic                  up_ready;
  logic                  intx_valid;
  pxirq_pkg::pxirq_intx_s intx_msg;
  logic                  intx_ready;
  logic                  slow          = 1'b0;
  int                    n_fail        = 0;
  int                    checks        = 0;

  always #50 ref_clk = ~ref_clk;

  // every input is driven by the bench, peer lines and virtual wires included
  pxirq_ctrl DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bus_irq_pins(bus_irq_pins), .hotplug_irq_a(hotplug_irq_a),
    .hotplug_irq_b(hotplug_irq_b), .peer_intx(peer_intx), .vw_valid(vw_valid),
    .vw_entry(vw_entry), .vw_level(vw_level),
    .eoi_valid(eoi_valid), .eoi_vector(eoi_vector), .bus_wr_valid(bus_wr_valid),
    .bus_wr(bus_wr), .bus_wr_ready(bus_wr_ready), .up_valid(up_valid), .up_msg(up_msg),
    .up_ready(up_ready), .intx_valid(intx_valid), .intx_msg(intx_msg),
    .intx_ready(intx_ready));

  pxirq_sink sink (.ref_clk(ref_clk), .slow(slow), .up_ready(up_ready),
    .intx_ready(intx_ready));

  task automatic chk(input logic [64:0] got, input logic [64:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    @(negedge ref_clk);
    chk({33'h0, reg_rdata}, {33'h0, e});
  endtask

  // waits for a handshake on one upstream port; x picks the legacy port
  task automatic wait_msg(input bit x, input logic [64:0] e);
    int k;
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while (!(x ? intx_valid && intx_ready : up_valid && up_ready) && k < 80);
    chk(x ? {intx_valid, 61'h0, intx_msg} : {up_valid, up_msg}, e);
    @(posedge ref_clk);
  endtask

  task automatic pin(input int p, input logic v);
    @(posedge ref_clk);
    bus_irq_pins[p] <= v;
  endtask

  task automatic test_fwd;
    rd(9'h100, 32'h0001_0000);
    rd(9'h1F0, 32'h0);
    chk({64'h0, bus_wr_ready}, 65'h1);
    @(posedge ref_clk);
    bus_wr       <= '{addr: 32'hFEE0_1000, data: 32'h0000_00A5};
    bus_wr_valid <= 1'b1;
    do @(negedge ref_clk); while (bus_wr_ready !== 1'b1);
    @(posedge ref_clk);
    bus_wr_valid <= 1'b0;
    wait_msg(0, {1'b1, 32'hFEE0_1000, 32'h0000_00A5});
    $display("forward test done");
  endtask

  // one pin per line, then hot-plug side B, all entries still masked
  task automatic test_legacy;
    for (int i = 0; i < 4; i++) begin
      pin(i * 5, 1'b1);
      wait_msg(1, {1'b1, 61'h0, 1'b1, 2'(i)});
      pin(i * 5, 1'b0);
      wait_msg(1, {1'b1, 61'h0, 1'b0, 2'(i)});
    end
    @(posedge ref_clk);
    hotplug_irq_b <= 1'b1;
    wait_msg(1, {1'b1, 61'h0, 3'h5});
    @(posedge ref_clk);
    hotplug_irq_b <= 1'b0;
    wait_msg(1, {1'b1, 61'h0, 3'h1});
    $display("legacy test done");
  endtask

  task automatic test_apic;
    wr(9'h000, 32'h1);
    wr(9'h12C, 32'h1234_0000);
    wr(9'h128, 32'h0000_0942);
    pin(5, 1'b1);
    wait_msg(0, {1'b1, 32'hFEE1_234C, 32'h0000_4942});
    pin(5, 1'b0);
    wr(9'h148, 32'h0001_2060);
    pin(9, 1'b1);
    wr(9'h148, 32'h0000_2060);
    pin(9, 1'b0);
    wait_msg(0, {1'b1, 32'hFEE0_0000, 32'h0000_4060});
    chk({64'h0, intx_valid}, 65'h0);
    $display("delivery test done");
  endtask

  // two level entries share one vector; the sink stalls meanwhile
  task automatic test_eoi;
    slow <= 1'b1;
    wr(9'h138, 32'h0000_8055);
    wr(9'h140, 32'h0000_8055);
    @(posedge ref_clk);
    bus_irq_pins[8:7] <= 2'b11;
    repeat (2) wait_msg(0, {1'b1, 32'hFEE0_0000, 32'h0000_C055});
    rd(9'h138, 32'h0000_C055);
    rd(9'h140, 32'h0000_C055);
    @(posedge ref_clk);
    bus_irq_pins[8:7] <= 2'b00;
    repeat (2) wait_msg(0, {1'b1, 32'hFEE0_0000, 32'h0000_8055});
    @(posedge ref_clk);
    eoi_valid  <= 1'b1;
    eoi_vector <= 8'h55;
    @(posedge ref_clk);
    eoi_valid  <= 1'b0;
    rd(9'h138, 32'h0000_8055);
    rd(9'h140, 32'h0000_8055);
    $display("end of interrupt test done");
  endtask

  // virtual wire into entry 16 and a refused one into entry 3, hot-plug
  // side A and peer lines on legacy, then line A sources all unmasked
  task automatic test_vw;
    wr(9'h180, 32'h0000_0077);
    @(posedge ref_clk);
    vw_valid <= 1'b1;
    vw_entry <= 5'h10;
    vw_level <= 1'b1;
    @(posedge ref_clk);
    vw_entry <= 5'h03;
    @(posedge ref_clk);
    vw_valid <= 1'b0;
    wait_msg(0, {1'b1, 32'hFEE0_0000, 32'h0000_4077});
    rd(9'h004, 32'h0);
    @(posedge ref_clk);
    hotplug_irq_a <= 1'b1;
    wait_msg(1, {1'b1, 61'h0, 3'h4});
    @(posedge ref_clk);
    hotplug_irq_a <= 1'b0;
    wait_msg(1, {1'b1, 61'h0, 3'h0});
    @(posedge ref_clk);
    peer_intx <= 4'h4;
    wait_msg(1, {1'b1, 61'h0, 3'h6});
    @(posedge ref_clk);
    peer_intx <= 4'h0;
    wait_msg(1, {1'b1, 61'h0, 3'h2});
    wr(9'h100, 32'h0);
    wr(9'h120, 32'h0);
    wr(9'h160, 32'h0);
    wr(9'h1B8, 32'h0);
    pin(0, 1'b1);
    wait_msg(0, {1'b1, 32'hFEE0_0000, 32'h0000_4000});
    chk({64'h0, intx_valid}, 65'h0);
    $display("virtual wire test done");
  endtask

  // guard against a hang; the tests need a few hundred cycles
  initial begin
    #1000000;
    n_fail++;
    end_sim();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    test_fwd();
    test_legacy();
    test_apic();
    test_eoi();
    test_vw();
    end_sim();
  end
endmodule
